// [rsf_frame_handler.sv]
// Operation
// - Half-duplex: no receive while driving line
// - Station 1..247 unique, 0 is broadcast
// - Broadcast executed, never answered
// - Own-address request gets exactly one reply
// - Failed or impossible request gets fault reply
// - Line idle 3.5 characters before sending
// - Order: address, command, data, check word
// - 3.5 character idle ends the frame
// - Gap over 1.5 characters restarts frame
// - Shorter gap continues previous frame
// - Bad check word flags fault, no execution
// - Line activity monitored at all times; received bytes are ignored while the driver is on
// - First byte compared with station or broadcast
// - Command 03 reads, 06 writes one word
// - Read of more than twelve words refused
// - Read request field order fixed
// - Check register starts at all ones
// - Shift right, xor a001 when bit out set
// - Write reply echoes request exactly
`default_nettype none
`include "rsf_params.svh"

module rsf_frame_handler #(
	parameter int unsigned GAP_SHORT_CYCLES = int'(`RSF_GAP_CYCLES(`RSF_GAP_SHORT_TENTHS)),
	parameter int unsigned GAP_LONG_CYCLES  = int'(`RSF_GAP_CYCLES(`RSF_GAP_LONG_TENTHS))
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic [7:0]               stationAddr,
	input  wire logic                     rxValid,
	input  wire logic [7:0]               rxData,
	input  wire logic                     rxError,
	input  wire logic                     txLineBusy,
	output logic                          txValid,
	input  wire logic                     txReady,
	output logic [7:0]                    txData,
	output logic                          lineOe_n,
	output logic                          accValid,
	output rsf_pkg::rsf_acc_req_type      accReq,
	input  wire logic                     accDone,
	input  wire rsf_pkg::rsf_acc_rsp_type accRsp,
	output logic                          commFault
);

	localparam logic [`RSF_IDLE_W-1:0] GAP_SHORT = `RSF_IDLE_W'(GAP_SHORT_CYCLES);
	localparam logic [`RSF_IDLE_W-1:0] GAP_LONG  = `RSF_IDLE_W'(GAP_LONG_CYCLES);

	rsf_pkg::rsf_ctl_type r;
	rsf_pkg::rsf_ctl_type next_r;
	logic                 bufInReady;
	logic                 rxTake;
	logic                 frameEnd;
	logic                 eval;
	logic                 addrMatch;
	logic                 isBcast;
	logic                 crcBad;
	logic                 loadNow;
	logic [7:0]           cmd;
	logic [15:0]          startAddr;
	logic [15:0]          reqWord;
	logic [4:0]           txLen;
	logic [7:0]           respByte;
	logic [4:0]           dataOfs;

	////////////////////////////////////////////////////////////////////////////
	// One byte of the check word
	// bytewise check
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] v;
		v = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			v = v[0] ? ((v >> 1) ^ `RSF_CRC_POLY) : (v >> 1);
		end
		return v;
	endfunction : crc_step

	////////////////////////////////////////////////////////////////////////////
	// Request fields, fixed positions of the eight-byte requests
	// field positions
	assign cmd       = r.rxBuf[1];
	assign startAddr = {r.rxBuf[2], r.rxBuf[3]};
	assign reqWord   = {r.rxBuf[4], r.rxBuf[5]};

	// address filter; a station outside 1..247 acts on broadcast only
	assign isBcast   = (r.rxBuf[0] == `RSF_ADDR_BCAST);
	assign addrMatch = isBcast || ((r.rxBuf[0] == stationAddr) && (stationAddr <= `RSF_ADDR_MAX)
		&& (stationAddr != `RSF_ADDR_BCAST));

	// a good frame leaves the running check at zero
	assign crcBad = r.rxBad || (r.rxCrc != 16'h0000) || (r.rxCount < `RSF_MIN_LEN);

	// receive only while the driver is off
	assign rxTake   = rxValid && !r.driverOn;
	assign frameEnd = r.inFrame && (r.idleCnt >= GAP_LONG) && !rxTake;
	assign eval     = frameEnd && (r.state == rsf_pkg::RSF_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Reply length and byte selection
	always_comb begin
		if (r.exc != 8'h00) begin
			txLen = `RSF_FAULT_LEN;
		end else if (cmd == `RSF_CMD_WRITE) begin
			txLen = 5'(`RSF_REQ_LEN);
		end else begin
			txLen = `RSF_READ_HDR_LEN + {reqWord[3:0], 1'b0};
		end
		dataOfs = r.byteIdx - 5'h03;
		// address, command, data, then check word low and high
		if (r.byteIdx == txLen - 5'h02) begin
			respByte = r.txCrc[7:0];
		end else if (r.byteIdx == txLen - 5'h01) begin
			respByte = r.txCrc[15:8];
		end else if (r.byteIdx == 5'h00) begin
			respByte = r.rxBuf[0];
		end else if (r.byteIdx == 5'h01) begin
			respByte = (r.exc != 8'h00) ? (cmd | `RSF_CMD_FAULT_BIT) : cmd;
		end else if (r.exc != 8'h00) begin
			respByte = r.exc;
		end else if (cmd == `RSF_CMD_WRITE) begin
			respByte = r.rxBuf[r.byteIdx[2:0]];
		end else if (r.byteIdx == 5'h02) begin
			respByte = {reqWord[6:0], 1'b0};
		end else begin
			respByte = dataOfs[0] ? r.words[dataOfs[4:1]][7:0] : r.words[dataOfs[4:1]][15:8];
		end
	end

	// first byte waits for a long silence
	assign loadNow = (r.state == rsf_pkg::RSF_SEND) && (!r.txLoad || bufInReady)
		&& (r.byteIdx != txLen) && ((r.byteIdx != 5'h00) || (r.idleCnt >= GAP_LONG));

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_r = r;
		next_r.accValid = 1'b0;
		next_r.commFault = 1'b0;
		if (r.txLoad && bufInReady) begin
			next_r.txLoad = 1'b0;
		end
		// silence counter runs in every state, saturating
		if (rxTake || txLineBusy) begin
			next_r.idleCnt = '0;
		end else if (r.idleCnt < GAP_LONG) begin
			next_r.idleCnt = r.idleCnt + `RSF_IDLE_W'(1);
		end
		if (rxTake) begin
			if (!r.inFrame || (r.idleCnt > GAP_SHORT)) begin
				// broken frame dropped, byte taken as address
				next_r.inFrame = 1'b1;
				next_r.rxCount = 4'h1;
				next_r.rxBuf[0] = rxData;
				next_r.rxCrc = crc_step(`RSF_CRC_INIT, rxData);
				next_r.rxBad = rxError;
			end else begin
				if (r.rxCount < `RSF_REQ_LEN) begin
					next_r.rxBuf[r.rxCount[2:0]] = rxData;
				end
				if (r.rxCount != 4'hf) begin
					next_r.rxCount = r.rxCount + 4'h1;
				end
				next_r.rxCrc = crc_step(r.rxCrc, rxData);
				next_r.rxBad = r.rxBad || rxError;
			end
		end else if (frameEnd) begin
			next_r.inFrame = 1'b0;
		end
		case (r.state)
			rsf_pkg::RSF_IDLE: begin
				if (eval && addrMatch) begin
					next_r.bcast = isBcast;
					next_r.wordIdx = 4'h0;
					next_r.byteIdx = 5'h00;
					next_r.exc = 8'h00;
					next_r.state = rsf_pkg::RSF_ACCESS;
					if (crcBad) begin
						next_r.commFault = 1'b1;
						next_r.exc = `RSF_EXC_COMM;
						next_r.state = isBcast ? rsf_pkg::RSF_IDLE : rsf_pkg::RSF_SEND;
					// only read and single write are served
					end else if ((cmd != `RSF_CMD_READ) && (cmd != `RSF_CMD_WRITE)) begin
						next_r.exc = `RSF_EXC_FUNC;
						next_r.state = isBcast ? rsf_pkg::RSF_IDLE : rsf_pkg::RSF_SEND;
					// count outside 1..12 cannot be served
					end else if ((r.rxCount != `RSF_REQ_LEN) || ((cmd == `RSF_CMD_READ)
						&& ((reqWord == 16'h0000) || (reqWord > `RSF_READ_MAX_WORDS)))) begin
						next_r.exc = `RSF_EXC_VALUE;
						next_r.state = isBcast ? rsf_pkg::RSF_IDLE : rsf_pkg::RSF_SEND;
					end
				end
			end
			rsf_pkg::RSF_ACCESS: begin
				// One word access per request word
				next_r.accValid = 1'b1;
				next_r.accReq.write = (cmd == `RSF_CMD_WRITE);
				next_r.accReq.addr = startAddr + {12'h000, r.wordIdx};
				next_r.accReq.data = reqWord;
				next_r.state = rsf_pkg::RSF_WAIT;
			end
			rsf_pkg::RSF_WAIT: begin
				if (accDone) begin
					next_r.words[r.wordIdx] = accRsp.data;
					// broadcast ends here without a reply
					if (accRsp.fault || (cmd == `RSF_CMD_WRITE)
						|| ({12'h000, r.wordIdx} + 16'h0001 == reqWord)) begin
						next_r.exc = accRsp.fault ? `RSF_EXC_ADDR : 8'h00;
						next_r.state = r.bcast ? rsf_pkg::RSF_IDLE : rsf_pkg::RSF_SEND;
					end else begin
						next_r.wordIdx = r.wordIdx + 4'h1;
						next_r.state = rsf_pkg::RSF_ACCESS;
					end
				end
			end
			rsf_pkg::RSF_SEND: begin
				// one reply, normal or fault, then back to idle
				if (loadNow) begin
					next_r.txLoad = 1'b1;
					next_r.txByte = respByte;
					next_r.byteIdx = r.byteIdx + 5'h01;
					// Check word bytes stay out of their own sum, or the high byte goes out corrupted
					if (r.byteIdx < txLen - 5'h02) begin
						next_r.txCrc = crc_step((r.byteIdx == 5'h00) ? `RSF_CRC_INIT : r.txCrc, respByte);
					end
				end else if (r.byteIdx == txLen) begin
					next_r.state = rsf_pkg::RSF_IDLE;
				end
			end
			default: begin
				next_r.state = rsf_pkg::RSF_IDLE;
			end
		endcase
		// driver held on until the last byte has left the line
		// A byte still moving into the buffer counts, else a fast drain drops the driver early
		next_r.driverOn = (next_r.state == rsf_pkg::RSF_SEND) || next_r.txLoad || r.txLoad || txValid || txLineBusy;
	end

	// Register the copy
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-entry buffer toward the transmitter; a stall holds the sequencer
	rsf_pair_buffer #(
		.WIDTH(8)
	) i_rsf_pair_buffer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.inValid (r.txLoad),
		.inReady (bufInReady),
		.inData  (r.txByte),
		.outValid(txValid),
		.outReady(txReady),
		.outData (txData)
	);

	// Outputs straight from the state flops
	assign lineOe_n  = !r.driverOn;
	assign accValid  = r.accValid;
	assign accReq    = r.accReq;
	assign commFault = r.commFault;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// bytes only leave with the driver on
	a_drive_while_tx:
		assert property (txValid |-> !lineOe_n)
		else $error("byte offered with line driver off");

	// broadcast never reaches the send state
	a_bcast_silent:
		assert property ((r.state == rsf_pkg::RSF_SEND) |-> !r.bcast)
		else $error("broadcast frame being answered");

	// silence seen when the first reply byte was queued
	a_gap_before_tx:
		assert property (((r.state == rsf_pkg::RSF_SEND) && (r.byteIdx == 5'h00) ##1 (r.byteIdx == 5'h01))
			|-> ($past(r.idleCnt) >= GAP_LONG))
		else $error("reply started without line silence");

	// reply opens with the own station address
	a_reply_addr:
		assert property ((loadNow && (r.byteIdx == 5'h00)) |=> (r.txByte == r.rxBuf[0]) && r.txLoad)
		else $error("reply does not open with station address");

	// frames judged only after the long silence
	a_frame_end:
		assert property (eval |-> (r.idleCnt >= GAP_LONG) && r.inFrame ##1 !r.inFrame || rxValid)
		else $error("frame judged before silence");

	a_late_restart:
		assert property ((rxTake && r.inFrame && (r.idleCnt > GAP_SHORT))
			|=> (r.rxCount == 4'h1) && !r.rxBad || $past(rxError))
		else $error("late byte not taken as new address");

	// bad check word raises fault and skips access
	a_crc_fault:
		assert property ((eval && addrMatch && crcBad) |=> commFault && !accValid ##1 !accValid)
		else $error("corrupt frame executed or not flagged");

	// oversized read answered with a fault
	a_read_limit:
		assert property ((eval && addrMatch && !crcBad && !isBcast && (cmd == `RSF_CMD_READ)
			&& (reqWord > `RSF_READ_MAX_WORDS)) |=> (r.state == rsf_pkg::RSF_SEND) && (r.exc == `RSF_EXC_VALUE))
		else $error("oversized read not refused");

	// foreign frame leaves the sequencer idle
	a_foreign_drop:
		assert property ((eval && !addrMatch) |=> (r.state == rsf_pkg::RSF_IDLE) && !commFault [*2])
		else $error("foreign frame acted upon");

	// write reply repeats the register address high byte
	a_write_echo:
		assert property ((loadNow && (r.exc == 8'h00) && (cmd == `RSF_CMD_WRITE) && (r.byteIdx == 5'h02))
			|=> (r.txByte == r.rxBuf[2]))
		else $error("write reply differs from request");

	// Main scenarios
	c_read_reply:
		cover property ((r.state == rsf_pkg::RSF_SEND) && (r.exc == 8'h00) && (cmd == `RSF_CMD_READ));
	c_write_reply:
		cover property ((r.state == rsf_pkg::RSF_SEND) && (r.exc == 8'h00) && (cmd == `RSF_CMD_WRITE));
	c_fault_reply:
		cover property ((r.state == rsf_pkg::RSF_SEND) && (r.exc != 8'h00));
	c_bcast_write:
		cover property (accValid && r.bcast && accReq.write);

endmodule : rsf_frame_handler

`default_nettype wire

// [rsf_frame_handler_tb.sv]
`default_nettype none

module rsf_frame_handler_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef logic [7:0] rsf_bytes_type[$];
	localparam int LONG = 14;
	logic                      sys_clk;
	logic                      rst_n;
	logic [7:0]                stationAddr;
	logic [7:0]                rxData;
	logic [7:0]                txData;
	logic                      rxValid, rxError, txLineBusy, txValid, txReady, lineOe_n, accValid, accDone, commFault;
	rsf_pkg::rsf_acc_req_type  accReq;
	rsf_pkg::rsf_acc_rsp_type  accRsp;
	rsf_pkg::rsf_acc_req_type  accLog[$];
	rsf_bytes_type             noReply;
	logic [15:0]               faultAt;
	int                        mismatches, samplesChecked, pulses;

	rsf_frame_handler #(.GAP_SHORT_CYCLES(6), .GAP_LONG_CYCLES(LONG)) i_rsf_frame_handler (
		.sys_clk(sys_clk), .rst_n(rst_n), .stationAddr(stationAddr), .rxValid(rxValid), .rxData(rxData),
		.rxError(rxError), .txLineBusy(txLineBusy), .txValid(txValid), .txReady(txReady), .txData(txData),
		.lineOe_n(lineOe_n), .accValid(accValid), .accReq(accReq), .accDone(accDone), .accRsp(accRsp),
		.commFault(commFault));

	rsf_host_model i_rsf_host_model (
		.sys_clk(sys_clk), .rxValid(rxValid), .rxData(rxData), .rxError(rxError), .txLineBusy(txLineBusy),
		.txValid(txValid), .txReady(txReady), .txData(txData), .lineOe_n(lineOe_n));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Parameter store: two-cycle latency, fault on one chosen address
	initial begin
		accDone = 1'b0;
		accRsp = '0;
		forever begin
			@(posedge sys_clk);
			if (accValid === 1'b1) begin
				accLog.push_back(accReq);
				repeat (2) @(posedge sys_clk);
				#2;
				accDone = 1'b1;
				accRsp.fault = accReq.addr === faultAt;
				accRsp.data = ~accReq.addr;
				@(posedge sys_clk);
				#2;
				accDone = 1'b0;
				accRsp = ~accRsp;
			end
		end
	end

	always @(posedge sys_clk)
		if (commFault === 1'b1)
			pulses++;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Appends the check word, low byte first
	function automatic rsf_bytes_type framed(input rsf_bytes_type q);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return {q, c[7:0], c[15:8]};
	endfunction : framed

	function automatic rsf_bytes_type faulted(input logic [7:0] cmd, input logic [7:0] code);
		return framed({8'h11, cmd | 8'h80, code});
	endfunction : faulted

	// Send a request, then gather the reply or watch a silent window
	task automatic transact(input rsf_bytes_type req, input rsf_bytes_type rsp, input int errAt);
		int n;
		i_rsf_host_model.seen.delete();
		i_rsf_host_model.firstTx = -1;
		accLog.delete();
		pulses = 0;
		foreach (req[i])
			i_rsf_host_model.send_byte(req[i], i == errAt);
		n = 0;
		while (n < 600 && !(rsp.size() > 0 && i_rsf_host_model.seen.size() >= rsp.size() && lineOe_n === 1'b1)) begin
			@(posedge sys_clk);
			n++;
		end
		check("driver released", {31'h0, lineOe_n}, 32'h1);
		check("offered while off", 32'(i_rsf_host_model.offLine), 32'h0);
		check("reply length", 32'(i_rsf_host_model.seen.size()), 32'(rsp.size()));
		foreach (rsp[i])
			check("reply byte", {24'h0, i_rsf_host_model.seen[i]}, {24'h0, rsp[i]});
		if (rsp.size() > 0)
			check("quiet gap", 32'(i_rsf_host_model.firstTx - i_rsf_host_model.lastRx >= LONG), 32'h1);
	endtask : transact

	////////////////////////////////////////////////////////////////////////////////
	// Read of n words from f002; the store answers each with the inverted address
	task automatic t_read(input logic [7:0] n);
		rsf_bytes_type rsp;
		rsp = {8'h11, 8'h03, 8'(2 * n)};
		for (int i = 0; i < n; i++)
			rsp = {rsp, 8'h0f, ~(8'h02 + 8'(i))};
		rsp = (n > 12) ? faulted(8'h03, 8'h03) : framed(rsp);
		// start then count, check word last
		transact(framed({8'h11, 8'h03, 8'hf0, 8'h02, 8'h00, n}), rsp, -1);
		check("read accesses", 32'(accLog.size()), n > 12 ? 32'h0 : 32'(n));
		foreach (accLog[i])
			check("read address", {16'h0, accLog[i].addr}, 32'hf002 + i);
		$display("read of %0d words done", n);
	endtask : t_read

	// Write echo while the host stalls the first reply bytes
	task automatic t_write;
		rsf_bytes_type q;
		q = framed({8'h11, 8'h06, 8'hf0, 8'h0a, 8'h13, 8'h88});
		fork
			begin
				#2;
				i_rsf_host_model.stall = 1'b1;
				repeat (60) @(posedge sys_clk);
				#2;
				i_rsf_host_model.stall = 1'b0;
			end
		join_none
		transact(q, q, -1);
		check("write target", {15'h0, accLog[0].write, accLog[0].addr}, 32'h0001f00a);
		check("write value", {16'h0, accLog[0].data}, 32'h00001388);
		$display("write echo done");
	endtask : t_write

	// Broadcast carried out unanswered; other stations ignored
	task automatic t_quiet;
		transact(framed({8'h00, 8'h06, 8'hf0, 8'h0a, 8'h00, 8'h01}), noReply, -1);
		check("broadcast accesses", 32'(accLog.size()), 32'h1);
		transact(framed({8'h22, 8'h03, 8'hf0, 8'h02, 8'h00, 8'h01}), noReply, -1);
		check("foreign accesses", 32'(accLog.size()), 32'h0);
		$display("silent cases done");
	endtask : t_quiet

	// Corrupt check word, character error, bad command, failing access
	task automatic t_faults;
		rsf_bytes_type q;
		q = framed({8'h11, 8'h03, 8'hf0, 8'h02, 8'h00, 8'h01});
		q[7] = q[7] ^ 8'h01;
		transact(q, faulted(8'h03, 8'h04), -1);
		check("crc fault pulse", 32'(pulses), 32'h1);
		check("crc accesses", 32'(accLog.size()), 32'h0);
		transact(framed({8'h11, 8'h03, 8'hf0, 8'h02, 8'h00, 8'h01}), faulted(8'h03, 8'h04), 3);
		check("rx error pulse", 32'(pulses), 32'h1);
		transact(framed({8'h11, 8'h10, 8'hf0, 8'h02, 8'h00, 8'h01}), faulted(8'h10, 8'h01), -1);
		faultAt = 16'hf003;
		transact(framed({8'h11, 8'h03, 8'hf0, 8'h02, 8'h00, 8'h03}), faulted(8'h03, 8'h02), -1);
		check("stop at failed word", 32'(accLog.size()), 32'h2);
		faultAt = 16'h0000;
		$display("fault replies done");
	endtask : t_faults

	// Pause over the short gap but under LONG drops a partial frame; short pause joins two frames
	task automatic t_gaps;
		rsf_bytes_type q;
		i_rsf_host_model.send_byte(8'h11, 1'b0);
		i_rsf_host_model.send_byte(8'h03, 1'b0);
		repeat (10) @(posedge sys_clk);
		t_read(8'd1);
		q = framed({8'h11, 8'h03, 8'hf0, 8'h02, 8'h00, 8'h01});
		// Joined frame breaks the running check, so it is a comm fault
		transact({q, q}, faulted(8'h03, 8'h04), -1);
		check("join fault pulse", 32'(pulses), 32'h1);
		check("join accesses", 32'(accLog.size()), 32'h0);
		$display("gap handling done");
	endtask : t_gaps

	task automatic endOfTest;
		$display("checks %0d, mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : endOfTest

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		stationAddr = 8'h11;
		rst_n = 1'b0;
		faultAt = 16'h0000;
		mismatches = 0;
		samplesChecked = 0;
		pulses = 0;
		repeat (12) @(posedge sys_clk);
		#2;
		rst_n = 1'b1;
		t_read(8'd2);
		t_read(8'd12);
		t_read(8'd13);
		t_write;
		t_quiet;
		t_faults;
		t_gaps;
		endOfTest;
	end

	// Run needs about two thousand cycles; fifteen times that means a hang
	initial begin
		repeat (30000) @(posedge sys_clk);
		mismatches++;
		endOfTest;
	end

endmodule : rsf_frame_handler_tb

`default_nettype wire

// [rsf_host_model.sv]
`default_nettype none

module rsf_host_model (
	input  wire logic       sys_clk,
	output logic            rxValid,
	output logic [7:0]      rxData,
	output logic            rxError,
	output logic            txLineBusy,
	input  wire logic       txValid,
	output logic            txReady,
	input  wire logic [7:0] txData,
	input  wire logic       lineOe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] seen[$];
	logic       stall = 1'b0;
	int         busyLeft = 0;
	int         cycle = 0;
	int         lastRx = 0;
	int         firstTx = -1;
	int         offLine = 0;

	initial begin
		rxValid = 1'b0;
		rxData = 8'h00;
		rxError = 1'b0;
		txLineBusy = 1'b0;
		txReady = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One character; data goes to its inverse afterwards so no stale value lingers
	task automatic send_byte(input logic [7:0] b, input logic err);
		while (lineOe_n !== 1'b1)
			@(posedge sys_clk);
		@(posedge sys_clk);
		#2;
		rxValid = 1'b1;
		rxData = b;
		rxError = err;
		@(posedge sys_clk);
		#2;
		lastRx = cycle;
		rxValid = 1'b0;
		rxData = ~b;
		rxError = 1'b0;
	endtask : send_byte

	////////////////////////////////////////////////////////////////////////////////
	// Shifter busy three cycles per byte; a stall holds ready low
	always @(posedge sys_clk) begin
		cycle = cycle + 1;
		if (txValid === 1'b1 && firstTx < 0)
			firstTx = cycle;
		// a byte offered with the driver off would collide on the line
		if (txValid === 1'b1 && lineOe_n !== 1'b0)
			offLine = offLine + 1;
		if (txValid === 1'b1 && txReady === 1'b1) begin
			seen.push_back(txData);
			busyLeft = 3;
		end else if (busyLeft > 0) begin
			busyLeft = busyLeft - 1;
		end
		txLineBusy <= #2 busyLeft > 0;
		txReady <= #2 !stall && busyLeft == 0;
	end

endmodule : rsf_host_model

`default_nettype wire

// [rsf_pair_buffer.sv]
`default_nettype none

module rsf_pair_buffer #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);

	typedef struct packed {
		logic [WIDTH-1:0] head;
		logic             headValid;
		logic [WIDTH-1:0] spare;
		logic             spareValid;
	} rsf_buf_state_type;

	rsf_buf_state_type r;
	rsf_buf_state_type next_r;
	logic              push;
	logic              pop;

	////////////////////////////////////////////////////////////////////////////
	// Head feeds the port; spare catches the word in flight during a stall
	always_comb begin
		next_r = r;
		push = inValid && !r.spareValid;
		pop = r.headValid && outReady;
		if (pop) begin
			if (r.spareValid) begin
				next_r.head = r.spare;
				next_r.spareValid = 1'b0;
			end else if (push) begin
				next_r.head = inData;
			end else begin
				next_r.headValid = 1'b0;
			end
		end else if (push) begin
			if (!r.headValid) begin
				next_r.head = inData;
				next_r.headValid = 1'b1;
			end else begin
				next_r.spare = inData;
				next_r.spareValid = 1'b1;
			end
		end
	end

	// Register the copy
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Full is a flop, so ready never depends on the drain side
	assign inReady  = !r.spareValid;
	assign outValid = r.headValid;
	assign outData  = r.head;

endmodule : rsf_pair_buffer

`default_nettype wire

// [rsf_params.svh]
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Line timing
`define RSF_CLK_HZ            64'd50000000
`define RSF_BAUD_DEFAULT      64'd9600
`define RSF_CHAR_BITS         64'd11
`define RSF_GAP_SHORT_TENTHS  64'd15
`define RSF_GAP_LONG_TENTHS   64'd35
// Least gap in cycles, rounded up
`define RSF_GAP_CYCLES(t) ((`RSF_CLK_HZ * `RSF_CHAR_BITS * (t) + 64'd10 * `RSF_BAUD_DEFAULT - 64'd1) / (64'd10 * `RSF_BAUD_DEFAULT))
`define RSF_IDLE_W            20

////////////////////////////////////////////////////////////////////////////////
// Frame fields
`define RSF_ADDR_BCAST        8'h00
`define RSF_ADDR_MAX          8'hf7
`define RSF_CMD_READ          8'h03
`define RSF_CMD_WRITE         8'h06
`define RSF_CMD_FAULT_BIT     8'h80
`define RSF_WORDS_MAX         12
`define RSF_READ_MAX_WORDS    16'h000c
`define RSF_EXC_FUNC          8'h01
`define RSF_EXC_ADDR          8'h02
`define RSF_EXC_VALUE         8'h03
`define RSF_EXC_COMM          8'h04
`define RSF_REQ_LEN           4'h8
`define RSF_MIN_LEN           4'h4
`define RSF_FAULT_LEN         5'h05
`define RSF_READ_HDR_LEN      5'h05

////////////////////////////////////////////////////////////////////////////////
// Check word
`define RSF_CRC_INIT          16'hffff
`define RSF_CRC_POLY          16'ha001

`endif

// [rsf_pkg.sv]
`default_nettype none
`include "rsf_params.svh"

package rsf_pkg;

	// Gray along idle, access, wait, send
	typedef enum logic [2:0] {
		RSF_IDLE   = 3'b000,
		RSF_ACCESS = 3'b001,
		RSF_WAIT   = 3'b011,
		RSF_SEND   = 3'b010
	} rsf_state_type;

	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [15:0] data;
	} rsf_acc_req_type;

	typedef struct packed {
		logic        fault;
		logic [15:0] data;
	} rsf_acc_rsp_type;

	typedef struct packed {
		rsf_state_type                      state;
		logic [`RSF_IDLE_W-1:0]             idleCnt;
		logic                               inFrame;
		logic                               rxBad;
		logic [3:0]                         rxCount;
		logic [7:0][7:0]                    rxBuf;
		logic [15:0]                        rxCrc;
		logic                               bcast;
		logic [7:0]                         exc;
		logic [3:0]                         wordIdx;
		logic [`RSF_WORDS_MAX-1:0][15:0]    words;
		logic [4:0]                         byteIdx;
		logic [15:0]                        txCrc;
		logic                               txLoad;
		logic [7:0]                         txByte;
		logic                               accValid;
		rsf_acc_req_type                    accReq;
		logic                               commFault;
		logic                               driverOn;
	} rsf_ctl_type;

endpackage : rsf_pkg

`default_nettype wire

// [rsf_placeholder_unused.sv]
`default_nettype none
`default_nettype wire
